// ===== design/fbsp_burst_ctr.sv
// Two-bit burst address generator, interleaved or linear
`timescale 1ns/1ps
module fbsp_burst_ctr (
    input  wire logic [fbsp_pkg::BURST_W-1:0] i_start,
    input  wire logic [fbsp_pkg::BURST_W-1:0] i_count,
    input  wire logic                         i_linear,
    output logic      [fbsp_pkg::BURST_W-1:0] o_low
);
    import fbsp_pkg::*;
    // Interleave is xor with start; linear adds and wraps in the group
    wire [BURST_W-1:0] lin_low = BURST_W'(i_start + i_count);
    wire [BURST_W-1:0] ilv_low = i_start ^ i_count;
    assign o_low = i_linear ? lin_low : ilv_low;
endmodule

// ===== design/fbsp_host.sv
// Controller end: issues bursts over the SRAM pins
`timescale 1ns/1ps
module fbsp_host #(
    parameter int DATA_W = fbsp_pkg::DATA_W_WIDE
) (
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_reset,
    input  wire logic                           i_req,
    input  wire logic                           i_write,
    input  wire logic                           i_use_ctrl,
    input  wire logic                           i_linear,
    input  wire logic [fbsp_pkg::ADDR_W-1:0]    i_addr,
    input  wire logic [fbsp_pkg::LANES-1:0]     i_lanes,
    input  wire logic [DATA_W-1:0]              i_wdata,
    input  wire logic                           i_snooze,
    output logic                                o_busy,
    output logic                                o_rvalid,
    output logic      [DATA_W-1:0]              o_rdata,
    fbsp_if.host                                bus
);
    import fbsp_pkg::*;

    if (DATA_W != DATA_W_WIDE && DATA_W != DATA_W_STD) begin : g_bad_width
        $error("fbsp_host: DATA_W must be 32 or 36");
    end

    fbsp_host_state_t  state_ff, nxt_state;
    logic [1:0]        beat_ff;
    logic              write_ff;
    logic              ctrl_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [LANES-1:0]  lanes_ff;
    logic [DATA_W-1:0] wdata_ff;
    logic              rvalid_ff;
    logic [DATA_W-1:0] rdata_ff;

    wire st_start = (state_ff == FBSP_START);
    wire st_burst = (state_ff == FBSP_BURST);
    wire st_done  = (state_ff == FBSP_DONE);
    wire last     = (beat_ff == 2'(BURST_LEN - 1));

    // Sequencer: start beat, three advance beats, one release cycle
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            FBSP_IDLE:  if (i_req) nxt_state = FBSP_START;
            FBSP_START: nxt_state = FBSP_BURST;
            FBSP_BURST: if (last) nxt_state = FBSP_DONE;
            FBSP_DONE:  nxt_state = FBSP_IDLE;
            default:    nxt_state = FBSP_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state_ff  <= FBSP_IDLE;
            beat_ff   <= '0;
            write_ff  <= 1'b0;
            ctrl_ff   <= 1'b0;
            addr_ff   <= '0;
            lanes_ff  <= '0;
            wdata_ff  <= '0;
            rvalid_ff <= 1'b0;
            rdata_ff  <= '0;
        end else begin
            state_ff  <= nxt_state;
            beat_ff   <= st_start ? 2'd1 : (st_burst ? 2'(beat_ff + 1'b1) : 2'd0);
            // Each word stands in the cycle after its own edge, so the
            // four read beats are taken on the burst and done edges
            rvalid_ff <= (st_burst | st_done) & ~write_ff;
            if (st_burst | st_done) rdata_ff <= bus.dq;
            if (state_ff == FBSP_IDLE && i_req) begin
                // Processor strobe cannot write on its first edge, so
                // writes are always issued with the controller strobe
                write_ff <= i_write;
                ctrl_ff  <= i_use_ctrl | i_write;
                addr_ff  <= i_addr;
                lanes_ff <= i_lanes;
                wdata_ff <= i_wdata;
            end
        end
    end

    // Pin drive: strobe on start beat, advance on burst beats
    assign bus.addr                 = addr_ff;
    assign bus.proc_addr_strobe_n   = ~(st_start & ~ctrl_ff);
    assign bus.ctrl_addr_strobe_n   = ~(st_start & ctrl_ff);
    assign bus.burst_advance_n      = ~st_burst;
    assign bus.burst_order_select_n = ~i_linear;
    assign bus.all_bytes_write_n    = ~(write_ff & (&lanes_ff) & (st_start | st_burst));
    assign bus.byte_write_gate_n    = ~(write_ff & (st_start | st_burst));
    assign bus.lane_write_n_bus     = ~(lanes_ff & {LANES{write_ff & (st_start | st_burst)}});
    assign bus.primary_select_n     = 1'b0;
    assign bus.select2              = 1'b1;
    assign bus.select3_n            = 1'b0;
    assign bus.out_enable_n         = write_ff;
    assign bus.snooze_request       = i_snooze & (state_ff == FBSP_IDLE);
    assign bus.dq_host_out          = wdata_ff;
    assign bus.dq_host_oe           = write_ff & (st_start | st_burst);

    assign o_busy   = (state_ff != FBSP_IDLE);
    assign o_rvalid = rvalid_ff;
    assign o_rdata  = rdata_ff;
endmodule

// ===== design/fbsp_if.sv
// Pin-level interface between SRAM port and its controller
`timescale 1ns/1ps
interface fbsp_if #(
    parameter int DATA_W = 36
);
    import fbsp_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              proc_addr_strobe_n;
    logic              ctrl_addr_strobe_n;
    logic              burst_advance_n;
    logic              burst_order_select_n;
    logic              all_bytes_write_n;
    logic              byte_write_gate_n;
    logic [LANES-1:0]  lane_write_n_bus;
    logic              primary_select_n;
    logic              select2;
    logic              select3_n;
    logic              out_enable_n;
    logic              snooze_request;
    logic [DATA_W-1:0] dq_host_out;
    logic              dq_host_oe;
    logic [DATA_W-1:0] dq_mem_out;
    logic              dq_mem_oe;

    // Resolved data wire value seen by both ends
    logic [DATA_W-1:0] dq;
    assign dq = dq_mem_oe ? dq_mem_out : (dq_host_oe ? dq_host_out : '0);

    modport mem (
        input  addr, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
        input  burst_order_select_n, all_bytes_write_n, byte_write_gate_n,
        input  lane_write_n_bus, primary_select_n, select2, select3_n,
        input  out_enable_n, snooze_request, dq,
        output dq_mem_out, dq_mem_oe
    );
    modport host (
        output addr, proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n,
        output burst_order_select_n, all_bytes_write_n, byte_write_gate_n,
        output lane_write_n_bus, primary_select_n, select2, select3_n,
        output out_enable_n, snooze_request, dq_host_out, dq_host_oe,
        input  dq
    );
endinterface

// ===== design/fbsp_mem.sv
// Device end: synchronous flow-through burst SRAM array
// Operation
// - 65,536 words of 32 or 36 bits
// - Three chip selects gate processor starts; two gate controller starts
// - Processor strobe starts read, captures address
// - Read data flows through in same cycle
// - Advance ignored on processor strobe edge
// - Read burst steps on advance, strobes high
// - Order select high gives interleaved bursts
// - Order select low gives linear bursts
// - Controller disables outputs and commands writes
// - Global write enable writes whole word
// - Byte gate plus lane enables write bytes
// - Lane enables ignored on processor strobe edge
// - Lane enable low forces outputs off
// - Data captured when lane enable low
// - Write burst steps on lane and advance
// - Controller strobe starts only if processor high
// - Controller start samples write enables at once
// - Primary select blocks processor start only
// - No global or gated lane enable active means read
// - Drive data only on enable and read
// - Snooze keeps data, lowers activity
`timescale 1ns/1ps
module fbsp_mem #(
    parameter int DATA_W = fbsp_pkg::DATA_W_WIDE
) (
    input  wire logic i_ref_clk,
    input  wire logic i_reset,
    fbsp_if.mem       bus
);
    import fbsp_pkg::*;

    localparam int LANE_W = DATA_W / LANES;

    // Elaboration check on data width option
    if (DATA_W != DATA_W_WIDE && DATA_W != DATA_W_STD) begin : g_bad_width
        $error("fbsp_mem: DATA_W must be 32 or 36");
    end

    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    logic [DATA_W-1:0]  mem_array [WORDS];
    logic [ADDR_W-1:0]  base_addr_ff;
    logic [BURST_W-1:0] count_ff;
    logic               active_ff;
    logic               read_ff;

    // ----------------------------------------------------------------
    // Start decode
    // ----------------------------------------------------------------
    wire sel_sec  = bus.select2 & ~bus.select3_n;
    wire sel_all  = ~bus.primary_select_n & sel_sec;
    wire p_low    = ~bus.proc_addr_strobe_n;
    wire c_low    = ~bus.ctrl_addr_strobe_n;
    // Snooze freezes the port; array contents are untouched
    wire awake    = ~bus.snooze_request;
    wire p_start  = awake & p_low & sel_all;
    wire c_start  = awake & c_low & ~p_low & sel_sec;
    wire deselect = awake & (p_low | c_low) & ~p_start & ~c_start;
    wire cont     = awake & active_ff & ~p_low & ~c_low;

    // ----------------------------------------------------------------
    // Write command decode
    // ----------------------------------------------------------------
    wire [LANES-1:0] lane_on = ~bus.lane_write_n_bus & {LANES{~bus.byte_write_gate_n}};
    wire glob_wr   = ~bus.all_bytes_write_n;
    // Processor start never writes: lanes ignored on that edge
    wire lanes_ok  = ~p_start;
    wire any_wr    = lanes_ok & (glob_wr | (|lane_on));
    wire wr_now    = any_wr & (c_start | cont);
    wire adv_now   = cont & ~bus.burst_advance_n;
    // Advance counts only on continuation edges, never on a start edge
    wire start_now = p_start | c_start;

    // ----------------------------------------------------------------
    // Address generation
    // ----------------------------------------------------------------
    // Beat timing of a four-word burst, one line per rising edge:
    //   edge 0  strobe low     count cleared, beat 0 registered
    //   edge 1  advance low    count 1, beat 1 registered
    //   edge 2  advance low    count 2, beat 2 registered
    //   edge 3  advance low    count 3, beat 3 registered
    //   later   advance high   count held, same word shown again
    // Stepped count is used on the edge that samples advance low, so
    // each word stands in the cycle after its own edge
    wire [BURST_W-1:0] step_cnt  = BURST_W'(count_ff + 1'b1);
    wire [BURST_W-1:0] hold_cnt  = adv_now ? step_cnt : count_ff;
    // Start clears the count: first beat is the pin address itself
    wire [BURST_W-1:0] nxt_count = start_now ? '0 : hold_cnt;

    // Upper bits from the pins on a start, else from the stored base;
    // they never change inside a burst, so the burst wraps in its group
    wire [ADDR_W-1:0]  cur_base  = start_now ? bus.addr : base_addr_ff;
    wire [BURST_W-1:0] low_bits;
    wire [ADDR_W-1:0]  eff_addr  = {cur_base[ADDR_W-1:BURST_W], low_bits};

    // Order select pin is low for the linear sequence
    fbsp_burst_ctr u_ctr (
        .i_start (cur_base[BURST_W-1:0]),
        .i_count (nxt_count),
        .i_linear(~bus.burst_order_select_n),
        .o_low   (low_bits)
    );

    // ----------------------------------------------------------------
    // Cycle state
    // ----------------------------------------------------------------
    // Edge kinds, in priority order:
    //   processor start   its strobe low, all three selects active: read
    //   controller start  its strobe low, processor strobe high, the two
    //                     secondary selects active: read or write
    //   continuation      both strobes high inside a live cycle
    //   deselect          a strobe low that neither start accepts
    //   idle              nothing sampled; state holds

    // Registered access address; the array read follows it with no
    // further stage, which is what makes the port flow-through
    logic [ADDR_W-1:0] acc_addr_ff;
    // Any edge that starts or continues a cycle updates the state
    wire upd_now  = start_now | cont;
    // No write enable sampled on the edge: the cycle is a read
    wire nxt_read = ~wr_now;

    // Reset branch holds constants only; array contents are not reset
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            base_addr_ff <= '0;
            count_ff     <= '0;
            active_ff    <= 1'b0;
            read_ff      <= 1'b0;
            acc_addr_ff  <= '0;
        end else if (upd_now) begin
            base_addr_ff <= cur_base;
            count_ff     <= nxt_count;
            active_ff    <= 1'b1;
            read_ff      <= nxt_read;
            acc_addr_ff  <= eff_addr;
        end else if (deselect) begin
            active_ff    <= 1'b0;
            read_ff      <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Write path: per-lane merge into the addressed word
    // ----------------------------------------------------------------
    // Write decode per edge:
    //   global enable low        every lane written
    //   global high, gate low    lanes whose enable is low
    //   neither                  read cycle, nothing written
    // Untouched lanes are written back with their old value, so one
    // process owns the whole array and it keeps a single driver
    wire [DATA_W-1:0] old_word = mem_array[eff_addr];
    wire [DATA_W-1:0] wr_word;

    // Global enable takes every lane, else only the gated lane enables
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        wire lane_wr = wr_now & (glob_wr | lane_on[g]);
        assign wr_word[g*LANE_W +: LANE_W] = lane_wr ? bus.dq[g*LANE_W +: LANE_W]
                                                     : old_word[g*LANE_W +: LANE_W];
    end

    // Data bus captured on the same edge that samples the enables
    always_ff @(posedge i_ref_clk) begin
        if (wr_now) begin
            mem_array[eff_addr] <= wr_word;
        end
    end

    // ----------------------------------------------------------------
    // Flow-through read and output enable
    // ----------------------------------------------------------------
    // Array read is combinational from the registered address
    assign bus.dq_mem_out = mem_array[acc_addr_ff];
    // Lane enables kill the drivers at once, before the edge, so a
    // controller turning to write never meets driven data
    wire lane_kill = |(~bus.lane_write_n_bus);
    // Drive only in a live read cycle with the output enable low
    wire in_read   = read_ff & active_ff;
    wire oe_pin    = ~bus.out_enable_n;
    // Snooze shuts the drivers at once, without waiting for a clock
    wire sleeping  = bus.snooze_request;
    assign bus.dq_mem_oe = in_read & oe_pin & ~lane_kill & ~sleeping;

    // ----------------------------------------------------------------
    // Notes for users of this port
    // ----------------------------------------------------------------
    // Snooze freezes the burst state instead of clearing it, so a
    // burst cut by snooze resumes on the first edge after it ends
    // A continuation edge with write enables but advance high writes
    // the same word again; the burst only moves on advance
    // After a write burst the port falls back to reading its last
    // word, so the output enable must stay high until the next start
    // The array has no reset: words read before any write are unknown
    // Only the two low address bits count; a burst never leaves its
    // aligned group of four, whichever order is selected
    // Deselect drops the cycle but keeps the address registers; the
    // next start reloads them anyway
    // Output enable, snooze and the lane enables act on the drivers without a clock;
    // every other pin is taken on the rising edge
endmodule

// ===== design/fbsp_pkg.sv
// Shared constants and types for the flow-through burst SRAM port
package fbsp_pkg;
    localparam int WORDS       = 65536;
    localparam int ADDR_W      = 16;
    localparam int DATA_W_WIDE = 36;
    localparam int DATA_W_STD  = 32;
    localparam int LANES       = 4;
    localparam int BURST_W     = 2;
    localparam int BURST_LEN   = 4;

    // Host-side sequencer states
    typedef enum logic [3:0] {
        FBSP_IDLE  = 4'b0001,
        FBSP_START = 4'b0010,
        FBSP_BURST = 4'b0100,
        FBSP_DONE  = 4'b1000
    } fbsp_host_state_t;
endpackage

// ===== verif/fbsp_properties.sv
// Pin-level checks between the SRAM port and its controller
`timescale 1ns/1ps
module fbsp_properties (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset,
    input  wire logic       proc_addr_strobe_n,
    input  wire logic       ctrl_addr_strobe_n,
    input  wire logic       all_bytes_write_n,
    input  wire logic [3:0] lane_write_n_bus,
    input  wire logic       primary_select_n,
    input  wire logic       select2,
    input  wire logic       select3_n,
    input  wire logic       out_enable_n,
    input  wire logic       snooze_request,
    input  wire logic       dq_host_oe,
    input  wire logic       dq_mem_oe
);
    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    // Primary select left out: it never blocks a controller start
    wire start_any = !proc_addr_strobe_n || !ctrl_addr_strobe_n;
    wire sel_rest  = select2 && !select3_n;

    default clocking dc @(posedge i_ref_clk);
    endclocking
    default disable iff (i_reset);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    lane_kill_a: assert property (lane_write_n_bus != 4'hf |-> !dq_mem_oe)
        else $error("memory drives data while a lane write is low");
    oe_gate_a: assert property (out_enable_n |-> !dq_mem_oe)
        else $error("memory drives data with output enable off");
    no_contention_a: assert property (dq_host_oe |-> !dq_mem_oe)
        else $error("both ends drive the data wire");
    host_quiet_a: assert property (dq_host_oe |-> out_enable_n)
        else $error("controller writes without disabling memory outputs");
    write_quiet_a: assert property (
        !ctrl_addr_strobe_n && proc_addr_strobe_n && sel_rest && !all_bytes_write_n
        |=> !dq_mem_oe)
        else $error("memory drives data after a write start");
    read_drive_a: assert property (
        !proc_addr_strobe_n && !primary_select_n && sel_rest && !snooze_request
        ##1 (!out_enable_n && lane_write_n_bus == 4'hf && all_bytes_write_n
        && !snooze_request) |-> dq_mem_oe)
        else $error("read data not driven after processor start");
    deselect_a: assert property (
        !ctrl_addr_strobe_n && proc_addr_strobe_n && !sel_rest |=> !dq_mem_oe)
        else $error("data driven after a deselecting strobe");
    primary_block_a: assert property (
        !dq_mem_oe && !proc_addr_strobe_n && primary_select_n && ctrl_addr_strobe_n
        |=> !dq_mem_oe)
        else $error("processor start accepted with primary select off");
    snooze_off_a: assert property (snooze_request |-> !dq_mem_oe)
        else $error("memory drives data in snooze");
    // A live read resumes driving when the enable falls or snooze ends
    drive_cause_a: assert property (
        $rose(dq_mem_oe) |-> $past(start_any) || $past(start_any, 2)
        || $fell(out_enable_n) || $fell(snooze_request))
        else $error("memory drives data without a start strobe");
endmodule

// ===== verif/testbench.sv
// Bench driving both SRAM port ends through the controller user side
`timescale 1ns/1ps
module testbench;
    import fbsp_pkg::*;
    logic              i_ref_clk;
    logic              i_reset;
    logic              i_req;
    logic              i_write;
    logic              i_use_ctrl;
    logic              i_linear;
    logic [ADDR_W-1:0] i_addr;
    logic [LANES-1:0]  i_lanes;
    logic [31:0]       i_wdata;
    logic              i_snooze;
    logic              o_busy;
    logic              o_rvalid;
    logic [31:0]       o_rdata;
    int                bad_count = 0;
    int                cmp_count = 0;
    int                cycles    = 0;

    fbsp_if #(.DATA_W(32)) fbsp_if_i ();
    fbsp_mem #(.DATA_W(32)) fbsp_mem_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .bus(fbsp_if_i));
    fbsp_host #(.DATA_W(32)) fbsp_host_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_req(i_req), .i_write(i_write), .i_use_ctrl(i_use_ctrl), .i_linear(i_linear),
        .i_addr(i_addr), .i_lanes(i_lanes), .i_wdata(i_wdata), .i_snooze(i_snooze),
        .o_busy(o_busy), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .bus(fbsp_if_i));
    fbsp_properties fbsp_properties_i (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .proc_addr_strobe_n(fbsp_if_i.proc_addr_strobe_n),
        .ctrl_addr_strobe_n(fbsp_if_i.ctrl_addr_strobe_n),
        .all_bytes_write_n(fbsp_if_i.all_bytes_write_n),
        .lane_write_n_bus(fbsp_if_i.lane_write_n_bus),
        .primary_select_n(fbsp_if_i.primary_select_n), .select2(fbsp_if_i.select2),
        .select3_n(fbsp_if_i.select3_n), .out_enable_n(fbsp_if_i.out_enable_n),
        .snooze_request(fbsp_if_i.snooze_request), .dq_host_oe(fbsp_if_i.dq_host_oe),
        .dq_mem_oe(fbsp_if_i.dq_mem_oe));

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // Whole run needs about 135 cycles; 2000, some fifteen times that, is a hang
    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            bad_count++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One burst; the host fixes its length, so ten edges cover every beat
    task automatic xfer(input logic wr, input logic ctl, input logic lin,
                        input logic [15:0] a, input logic [3:0] ln,
                        input logic [31:0] d, input logic [31:0] exp);
        int beats;
        beats = 0;
        @(negedge i_ref_clk);
        i_req = 1'b1;
        i_write = wr;
        i_use_ctrl = ctl;
        i_linear = lin;
        i_addr = a;
        i_lanes = ln;
        i_wdata = d;
        @(negedge i_ref_clk);
        i_req = 1'b0;
        repeat (10) begin
            @(posedge i_ref_clk);
            #1;
            if (o_rvalid === 1'b1) begin
                beats++;
                chk(o_rdata, exp);
            end
        end
        chk(32'(beats), wr ? 32'h0 : 32'h4);
        chk({31'h0, o_busy}, 32'h0);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        i_reset = 1'b1;
        i_req = 1'b0;
        i_write = 1'b0;
        i_use_ctrl = 1'b0;
        i_linear = 1'b0;
        i_addr = 16'h0000;
        i_lanes = 4'h0;
        i_wdata = 32'h0;
        i_snooze = 1'b0;
        repeat (12) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_reset = 1'b0;
        xfer(1, 1, 0, 16'h1234, 4'hf, 32'ha5a5_0f0f, 32'h0);
        xfer(0, 0, 0, 16'h1234, 4'h0, 32'h0, 32'ha5a5_0f0f);
        xfer(0, 1, 1, 16'h1236, 4'h0, 32'h0, 32'ha5a5_0f0f);
        // Lanes 0 and 2 only: bytes 3 and 1 keep the old word
        xfer(1, 1, 1, 16'h1235, 4'h5, 32'h1122_3344, 32'h0);
        xfer(0, 0, 1, 16'h1237, 4'h0, 32'h0, 32'ha522_0f44);
        xfer(1, 1, 0, 16'hfffe, 4'hf, 32'h5a5a_c3c3, 32'h0);
        xfer(0, 0, 1, 16'hfffc, 4'h0, 32'h0, 32'h5a5a_c3c3);
        xfer(0, 1, 0, 16'h1233 + 16'h1, 4'h0, 32'h0, 32'ha522_0f44);
        @(negedge i_ref_clk);
        i_snooze = 1'b1;
        repeat (20) @(negedge i_ref_clk);
        i_snooze = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        xfer(0, 0, 0, 16'h1235, 4'h0, 32'h0, 32'ha522_0f44);
        results();
    end
endmodule
